// ==== verilog/hub_clock_pkg.sv ====
// Package of constants and carrier types for the hub clock and strap block
package hub_clock_pkg;

    // ****************************************************************
    // Sizes, bit clock divider end count and reset values
    // ****************************************************************
    localparam int         PORT_COUNT        = 4;
    localparam logic [3:0] PWR_OFF_ALL       = 4'hF;
    localparam logic [1:0] CORE_DIV_LAST     = 2'h3;
    localparam logic       STRAP_RESET_LEVEL = 1'b0;

    // Bit positions of the raw strap levels in the strap synchroniser
    localparam int         STRAP_CLK_BIT     = 3;
    localparam int         STRAP_BUS_BIT     = 2;
    localparam int         STRAP_MEM_BIT     = 1;
    localparam int         STRAP_PIN_BIT     = 0;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic bus_powered;
        logic rom_enabled;
        logic gang_power_mode;
    } strap_cfg_s;

    typedef struct packed {
        logic pll_power_down;
        logic pll_bypass;
        logic osc_power_down;
        logic core_from_ext;
    } clock_ctl_s;

    typedef enum logic [1:0] {
        CAP_WAIT,
        CAP_SETTLE,
        CAP_HOLD
    } capture_state_e;

endpackage : hub_clock_pkg

// ==== verilog/port_power_ctl.sv ====
// Per-port or ganged power switch control from overcurrent inputs
`timescale 1ns/1ps
module port_power_ctl
    import hub_clock_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  gang_power_mode,
    input  wire logic [PORT_COUNT-1:0] power_request,
    input  wire logic [PORT_COUNT-1:0] overcurrent_sync_n,
    output logic      [PORT_COUNT-1:0] port_power_enable_n
);

    logic [PORT_COUNT-1:0] tripped;
    logic                  any_trip;

    assign any_trip = ~&overcurrent_sync_n;

    // ****************************************************************
    // Per-port trip latch and output drive
    // ****************************************************************
    // Trip stays set until the port's power request is dropped, or in gang mode until every request is dropped
    genvar i;
    generate
        for (i = 0; i < PORT_COUNT; i++) begin : g_port
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    tripped[i] <= 1'b0;
                end else if (gang_power_mode ? any_trip : ~overcurrent_sync_n[i]) begin
                    tripped[i] <= 1'b1;
                end else if (gang_power_mode ? ~|power_request : ~power_request[i]) begin
                    tripped[i] <= 1'b0;
                end
            end

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    port_power_enable_n[i] <= 1'b1;
                end else if (gang_power_mode) begin
                    port_power_enable_n[i] <= ~(|power_request) | (|tripped);
                end else begin
                    port_power_enable_n[i] <= ~power_request[i] | tripped[i];
                end
            end
        end
    endgenerate

endmodule : port_power_ctl

// ==== verilog/hub_clock_and_strap_config.sv ====
// Clock source selection and strap decode for a four-port hub
//
// Contract
// - Clock source strap low: core runs from the on-chip PLL output.
// - Strap high: core from external high-rate clock; PLL powered down, bypassed.
// - Oscillator cell powered down while the clock source strap is high.
// - PLL mode: high-rate clock samples upstream data; bit clock derived by four.
// - Bus power strap high means bus-powered, low means self-powered.
// - Memory disable high: serial ROM interface off, its clock left undriven.
// - Memory disable low: serial ROM clock driven as a three-state output.
// - Memory disable low: shared pin is the two-way serial ROM data line.
// - Memory disable high: shared pin read as the gang power mode strap.
// - Gang mode switches all ports together; any overcurrent powers all off.
`timescale 1ns/1ps
module hub_clock_and_strap_config
    import hub_clock_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  clock_source_select,
    input  wire logic                  bus_power_strap,
    input  wire logic                  ext_memory_disable_n,
    input  wire logic                  serial_rom_data_or_gang_strap_in,
    output logic                       serial_rom_data_or_gang_strap_out,
    output logic                       serial_rom_data_or_gang_strap_oe,
    output logic                       serial_rom_clock_out,
    output logic                       serial_rom_clock_oe,
    input  wire logic                  rom_clock_request,
    input  wire logic                  rom_data_drive,
    input  wire logic                  rom_data_value,
    output logic                       rom_data_in,
    input  wire logic [PORT_COUNT-1:0] power_request,
    input  wire logic [PORT_COUNT-1:0] overcurrent_in_n,
    output logic      [PORT_COUNT-1:0] port_power_enable_n,
    output clock_ctl_s                 clock_ctl,
    output strap_cfg_s                 strap_cfg,
    output logic                       upstream_sample_en,
    output logic                       bit_clock_tick,
    output logic                       config_valid
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // Straps and overcurrent pins have no timing relation to the core clock
    logic [3:0]            strap_meta;
    logic [3:0]            strap_sync;
    logic [PORT_COUNT-1:0] ovc_meta;
    logic [PORT_COUNT-1:0] ovc_sync;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strap_meta <= '0;
            strap_sync <= '0;
        end else begin
            strap_meta[STRAP_CLK_BIT] <= clock_source_select;
            strap_meta[STRAP_BUS_BIT] <= bus_power_strap;
            strap_meta[STRAP_MEM_BIT] <= ext_memory_disable_n;
            strap_meta[STRAP_PIN_BIT] <= serial_rom_data_or_gang_strap_in;
            strap_sync                <= strap_meta;
        end
    end

    // Reset to the inactive level so that no port trips on reset release
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovc_meta <= PWR_OFF_ALL;
            ovc_sync <= PWR_OFF_ALL;
        end else begin
            ovc_meta <= overcurrent_in_n;
            ovc_sync <= ovc_meta;
        end
    end

    // ****************************************************************
    // Strap capture after reset release
    // ****************************************************************
    // The synchronisers fill on the first two edges after release, so the
    // capture waits for the third: earlier it would take their reset level
    capture_state_e cap_state;
    logic           capture_now;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cap_state <= CAP_WAIT;
        end else begin
            unique case (cap_state)
                CAP_WAIT:   cap_state <= CAP_SETTLE;
                CAP_SETTLE: cap_state <= CAP_HOLD;
                CAP_HOLD:   cap_state <= CAP_HOLD;
            endcase
        end
    end

    assign capture_now = (cap_state == CAP_HOLD) && !config_valid;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            config_valid <= 1'b0;
        end else if (capture_now) begin
            config_valid <= 1'b1;
        end
    end

    // Later strap changes are ignored until the next reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strap_cfg <= '{default: STRAP_RESET_LEVEL};
        end else if (capture_now) begin
            strap_cfg.bus_powered     <= strap_sync[STRAP_BUS_BIT];
            strap_cfg.rom_enabled     <= ~strap_sync[STRAP_MEM_BIT];
            // Shared pin only means gang mode with the ROM interface off
            strap_cfg.gang_power_mode <= strap_sync[STRAP_MEM_BIT]
                                         & strap_sync[STRAP_PIN_BIT];
        end
    end

    // ****************************************************************
    // Clock source selection
    // ****************************************************************
    // The clock strap is followed live; it is tied on the board anyway
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clock_ctl <= '0;
        end else begin
            clock_ctl.core_from_ext  <= strap_sync[STRAP_CLK_BIT];
            clock_ctl.pll_bypass     <= strap_sync[STRAP_CLK_BIT];
            clock_ctl.pll_power_down <= strap_sync[STRAP_CLK_BIT];
            clock_ctl.osc_power_down <= strap_sync[STRAP_CLK_BIT];
        end
    end

    // ****************************************************************
    // Bit clock derivation from the high-rate clock
    // ****************************************************************
    // The core clock stands for the high-rate clock; the two-bit divider
    // wraps by itself, so it needs no reload
    logic [1:0] core_div;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            core_div <= '0;
        end else begin
            core_div <= core_div + 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bit_clock_tick <= 1'b0;
        end else begin
            bit_clock_tick <= (core_div == CORE_DIV_LAST);
        end
    end

    // Upstream data is sampled on every high-rate edge out of reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            upstream_sample_en <= 1'b0;
        end else begin
            upstream_sample_en <= 1'b1;
        end
    end

    // ****************************************************************
    // Serial ROM pins
    // ****************************************************************
    // Until the straps are captured the pins stay released, so a shared
    // ROM is never disturbed by a hub that turns out to have it disabled
    logic rom_active;

    assign rom_active = strap_cfg.rom_enabled && config_valid;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            serial_rom_clock_out <= 1'b0;
            serial_rom_clock_oe  <= 1'b0;
        end else if (rom_active) begin
            serial_rom_clock_out <= rom_clock_request;
            serial_rom_clock_oe  <= 1'b1;
        end else begin
            serial_rom_clock_out <= 1'b0;
            serial_rom_clock_oe  <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            serial_rom_data_or_gang_strap_out <= 1'b0;
            serial_rom_data_or_gang_strap_oe  <= 1'b0;
        end else if (rom_active) begin
            serial_rom_data_or_gang_strap_out <= rom_data_value;
            serial_rom_data_or_gang_strap_oe  <= rom_data_drive;
        end else begin
            // Released so that the board strap level can be read
            serial_rom_data_or_gang_strap_out <= 1'b0;
            serial_rom_data_or_gang_strap_oe  <= 1'b0;
        end
    end

    // Read data is the synchronised pin level, held low when disabled
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rom_data_in <= 1'b0;
        end else if (rom_active) begin
            rom_data_in <= strap_sync[STRAP_PIN_BIT];
        end else begin
            rom_data_in <= 1'b0;
        end
    end

    // ****************************************************************
    // Downstream power switching
    // ****************************************************************
    // Requests are masked until the gang strap is known, so a port never
    // powers up under the wrong switching mode
    logic [PORT_COUNT-1:0] granted_request;

    assign granted_request = power_request & {PORT_COUNT{config_valid}};

    port_power_ctl u_power (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .gang_power_mode     (strap_cfg.gang_power_mode),
        .power_request       (granted_request),
        .overcurrent_sync_n  (ovc_sync),
        .port_power_enable_n (port_power_enable_n)
    );

endmodule : hub_clock_and_strap_config

// ==== tb/hub_strap_chk.sv ====
// Port-level assertions for the hub clock and strap block
`timescale 1ns/1ps
module hub_strap_chk
    import hub_clock_pkg::*;
(
    input wire logic                  sys_clk,
    input wire logic                  rst,
    input wire logic                  clock_source_select,
    input wire logic                  bus_power_strap,
    input wire logic                  serial_rom_clock_out,
    input wire logic                  serial_rom_clock_oe,
    input wire logic                  serial_rom_data_or_gang_strap_out,
    input wire logic                  serial_rom_data_or_gang_strap_oe,
    input wire logic                  rom_clock_request,
    input wire logic                  rom_data_drive,
    input wire logic                  rom_data_value,
    input wire logic [PORT_COUNT-1:0] port_power_enable_n,
    input wire clock_ctl_s            clock_ctl,
    input wire strap_cfg_s            strap_cfg,
    input wire logic                  bit_clock_tick,
    input wire logic                  config_valid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    clk_source_a: assert property (config_valid |->
        clock_ctl.core_from_ext == $past(clock_source_select, 3)) else $error("clock source");
    pll_power_a: assert property (config_valid |->
        {clock_ctl.pll_power_down, clock_ctl.pll_bypass, clock_ctl.osc_power_down}
        == {3{clock_ctl.core_from_ext}}) else $error("pll or oscillator power");
    rom_clk_off_a: assert property (config_valid && !strap_cfg.rom_enabled |->
        !serial_rom_clock_oe) else $error("rom clock driven while disabled");
    rom_clk_on_a: assert property (config_valid && strap_cfg.rom_enabled |=>
        serial_rom_clock_oe && serial_rom_clock_out == $past(rom_clock_request))
        else $error("rom clock");
    rom_data_a: assert property (config_valid && strap_cfg.rom_enabled |=>
        serial_rom_data_or_gang_strap_oe == $past(rom_data_drive) && (!$past(rom_data_drive)
        || serial_rom_data_or_gang_strap_out == $past(rom_data_value))) else $error("rom data");
    bus_capture_a: assert property ($rose(config_valid) |->
        strap_cfg.bus_powered == $past(bus_power_strap, 3)) else $error("bus power capture");
    strap_hold_a: assert property (config_valid && $past(config_valid) |->
        $stable(strap_cfg)) else $error("straps changed");
    gang_switch_a: assert property (config_valid && strap_cfg.gang_power_mode |->
        port_power_enable_n inside {4'h0, 4'hF}) else $error("ports not ganged");
    reset_out_a: assert property ($fell(rst) |->
        port_power_enable_n == PWR_OFF_ALL && !config_valid) else $error("reset outputs");
    bit_tick_a: assert property (bit_clock_tick |=>
        !bit_clock_tick [*3] ##1 bit_clock_tick) else $error("bit tick spacing");
    cover property (config_valid && strap_cfg.rom_enabled && serial_rom_clock_out);
    cover property (config_valid && strap_cfg.gang_power_mode && port_power_enable_n == 4'h0);
    cover property (config_valid && clock_ctl.core_from_ext);
endmodule : hub_strap_chk

// ==== tb/eeprom_strap_model.sv ====
// Serial ROM and board strap levels seen on the shared data/gang pin
`timescale 1ns/1ps
module eeprom_strap_model (
    input  wire logic sys_clk,
    input  wire logic ext_memory_disable_n,
    input  wire logic gang_level,
    input  wire logic serial_rom_clock_out,
    input  wire logic serial_rom_clock_oe,
    input  wire logic serial_rom_data_or_gang_strap_out,
    input  wire logic serial_rom_data_or_gang_strap_oe,
    output logic      serial_rom_data_or_gang_strap_in
);
    logic rom_bit = 1'b1;
    // New bit per clock pulse, so a stale level never looks right
    always @(posedge sys_clk) begin
        if (serial_rom_clock_oe && serial_rom_clock_out) rom_bit <= ~rom_bit;
    end
    always_comb begin
        if (serial_rom_data_or_gang_strap_oe) begin
            serial_rom_data_or_gang_strap_in = serial_rom_data_or_gang_strap_out;
        end else if (ext_memory_disable_n) begin
            serial_rom_data_or_gang_strap_in = gang_level;
        end else begin
            serial_rom_data_or_gang_strap_in = rom_bit;
        end
    end
endmodule : eeprom_strap_model

// ==== tb/hub_clock_and_strap_config_tb.sv ====
// Self-checking bench for the hub clock and strap block
`timescale 1ns/1ps
module hub_clock_and_strap_config_tb
    import hub_clock_pkg::*;
;
    logic                  sys_clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  clock_source_select, bus_power_strap, ext_memory_disable_n, gang_level;
    logic                  serial_rom_data_or_gang_strap_in, rom_data_in, upstream_sample_en;
    logic                  serial_rom_data_or_gang_strap_out, serial_rom_data_or_gang_strap_oe;
    logic                  serial_rom_clock_out, serial_rom_clock_oe, bit_clock_tick;
    logic                  rom_clock_request, rom_data_drive, rom_data_value, config_valid;
    logic [PORT_COUNT-1:0] power_request, overcurrent_in_n, port_power_enable_n;
    clock_ctl_s            clock_ctl;
    strap_cfg_s            strap_cfg;
    int                    failures = 0;
    int                    checks = 0;
    int                    n;
    logic [3:0]            cfgs [5] = '{4'hB, 4'h4, 4'h1, 4'hC, 4'h2};

    hub_clock_and_strap_config i_hub_clock_and_strap_config (
        .sys_clk                           (sys_clk),
        .rst                               (rst),
        .clock_source_select               (clock_source_select),
        .bus_power_strap                   (bus_power_strap),
        .ext_memory_disable_n              (ext_memory_disable_n),
        .serial_rom_data_or_gang_strap_in  (serial_rom_data_or_gang_strap_in),
        .serial_rom_data_or_gang_strap_out (serial_rom_data_or_gang_strap_out),
        .serial_rom_data_or_gang_strap_oe  (serial_rom_data_or_gang_strap_oe),
        .serial_rom_clock_out              (serial_rom_clock_out),
        .serial_rom_clock_oe               (serial_rom_clock_oe),
        .rom_clock_request                 (rom_clock_request),
        .rom_data_drive                    (rom_data_drive),
        .rom_data_value                    (rom_data_value),
        .rom_data_in                       (rom_data_in),
        .power_request                     (power_request),
        .overcurrent_in_n                  (overcurrent_in_n),
        .port_power_enable_n               (port_power_enable_n),
        .clock_ctl                         (clock_ctl),
        .strap_cfg                         (strap_cfg),
        .upstream_sample_en                (upstream_sample_en),
        .bit_clock_tick                    (bit_clock_tick),
        .config_valid                      (config_valid)
    );
    eeprom_strap_model i_eeprom_strap_model (
        .sys_clk                           (sys_clk),
        .ext_memory_disable_n              (ext_memory_disable_n),
        .gang_level                        (gang_level),
        .serial_rom_clock_out              (serial_rom_clock_out),
        .serial_rom_clock_oe               (serial_rom_clock_oe),
        .serial_rom_data_or_gang_strap_out (serial_rom_data_or_gang_strap_out),
        .serial_rom_data_or_gang_strap_oe  (serial_rom_data_or_gang_strap_oe),
        .serial_rom_data_or_gang_strap_in  (serial_rom_data_or_gang_strap_in)
    );

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Straps are {clock source, bus power, memory disable, gang level}
    task automatic boot(input logic [3:0] s);
        {clock_source_select, bus_power_strap, ext_memory_disable_n, gang_level} = s;
        power_request = 4'h0;
        rst = 1'b1;
        tick(3);
        rst = 1'b0;
        tick(2);
        chk(config_valid, 1'b0);
        tick(1);
        chk(config_valid, 1'b1);
    endtask : boot
    task automatic final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {rom_clock_request, rom_data_drive, rom_data_value} = 3'h0;
        overcurrent_in_n = 4'hF;
        foreach (cfgs[i]) begin
            boot(cfgs[i]);
            chk({clock_ctl, strap_cfg}, {{4{cfgs[i][3]}}, cfgs[i][2], !cfgs[i][1], &cfgs[i][1:0]});
            rom_clock_request = 1'b1;
            tick(1);
            chk({serial_rom_clock_oe, serial_rom_clock_out}, {2{!cfgs[i][1]}});
            rom_clock_request = 1'b0;
            {bus_power_strap, ext_memory_disable_n, gang_level} = ~cfgs[i][2:0];
            tick(6);
            chk(strap_cfg, {cfgs[i][2], !cfgs[i][1], &cfgs[i][1:0]});
        end
        boot(4'h2);
        power_request = 4'h3;
        tick(1);
        chk(port_power_enable_n, 4'hC);
        overcurrent_in_n = 4'hE;
        tick(5);
        chk(port_power_enable_n, 4'hD);
        overcurrent_in_n = 4'hF;
        boot(4'hB);
        power_request = 4'h4;
        tick(1);
        chk(port_power_enable_n, 4'h0);
        overcurrent_in_n = 4'hD;
        tick(5);
        chk(port_power_enable_n, 4'hF);
        overcurrent_in_n = 4'hF;
        boot(4'h4);
        {rom_data_drive, rom_data_value} = 2'h3;
        tick(1);
        chk({serial_rom_data_or_gang_strap_oe, serial_rom_data_or_gang_strap_out}, 8'h03);
        rom_data_drive = 1'b0;
        tick(3);
        chk(rom_data_in, 1'b1);
        tick(1);
        chk(rom_data_in, serial_rom_data_or_gang_strap_in);
        n = 0;
        repeat (40) begin
            tick(1);
            if (bit_clock_tick === 1'b1) n++;
        end
        chk(n[7:0], 8'h0A);
        chk(upstream_sample_en, 1'b1);
        final_report();
    end
    initial begin
        #20000;
        failures++;
        final_report();
    end
endmodule : hub_clock_and_strap_config_tb

bind hub_clock_and_strap_config hub_strap_chk i_hub_strap_chk (
    .sys_clk                           (sys_clk),
    .rst                               (rst),
    .clock_source_select               (clock_source_select),
    .bus_power_strap                   (bus_power_strap),
    .serial_rom_clock_out              (serial_rom_clock_out),
    .serial_rom_clock_oe               (serial_rom_clock_oe),
    .serial_rom_data_or_gang_strap_out (serial_rom_data_or_gang_strap_out),
    .serial_rom_data_or_gang_strap_oe  (serial_rom_data_or_gang_strap_oe),
    .rom_clock_request                 (rom_clock_request),
    .rom_data_drive                    (rom_data_drive),
    .rom_data_value                    (rom_data_value),
    .port_power_enable_n               (port_power_enable_n),
    .clock_ctl                         (clock_ctl),
    .strap_cfg                         (strap_cfg),
    .bit_clock_tick                    (bit_clock_tick),
    .config_valid                      (config_valid)
);
